/* File: src/sfp_pkg.sv */
// Package with constants and types for the serial flash and EEPROM programming port.
// Function
// RULE1 - Programming only while reset pin low.
// RULE2 - Refuse program or erase before unlock.
// RULE3 - Sample data in on rising clock.
// RULE4 - Shift data out on falling clock.
// RULE5 - Programmer keeps clock phases long enough.
// RULE6 - Programmer powers up with reset, clock low.
// RULE7 - Programmer waits 20 ms before unlock; the bench model settles 2 us after the pin falls.
// RULE8 - Echo 0x53 during third unlock byte.
// RULE9 - Programmer always sends four unlock bytes.
// RULE10 - Page buffer loaded bytewise, low first.
// RULE11 - Page write commits buffer to page.
// RULE12 - Programmer waits flash delay after page.
// RULE13 - Only polling reads while write busy.
// RULE14 - EEPROM byte write with auto erase.
// RULE15 - Programmer waits EEPROM delay after byte.
// RULE16 - Chip erase sets everything to 0xff.
// RULE17 - Read returns addressed memory content.
// RULE18 - Busy flash page reads as 0xff.
// RULE19 - Polling fails for 0xff; use delay.
// RULE20 - Busy EEPROM byte reads as 0xff.
// RULE21 - Programmer waits after fuse, erase writes.
// RULE22 - Reset high ends programming session.
// RULE23 - Unlock encoding ac 53 xx xx.
// RULE24 - Chip erase encoding ac 100xxxxx.
// RULE25 - EEPROM write encoding c0 a b d.
// RULE26 - Page write encoding 4c a b.
// RULE27 - Bytes travel most significant bit first.
package sfp_pkg;
   localparam int CLK_MHZ = 125;
   localparam real FLASH_WAIT_MS = 4.5;
   localparam real EEPROM_WAIT_MS = 9.0;
   localparam real ERASE_WAIT_MS = 9.0;
   localparam int FLASH_WAIT_CYC = int'(FLASH_WAIT_MS * 1000.0 * CLK_MHZ);
   localparam int EEPROM_WAIT_CYC = int'(EEPROM_WAIT_MS * 1000.0 * CLK_MHZ);
   localparam int ERASE_WAIT_CYC = int'(ERASE_WAIT_MS * 1000.0 * CLK_MHZ);
   localparam logic [7:0] OP_UNLOCK = 8'hac;
   localparam logic [7:0] UNLOCK_KEY = 8'h53;
   localparam logic [2:0] ERASE_KEY = 3'h4;
   localparam logic [7:0] OP_EE_WRITE = 8'hc0;
   localparam logic [7:0] OP_EE_READ = 8'ha0;
   localparam logic [7:0] OP_PG_WRITE = 8'h4c;
   localparam logic [7:0] OP_LOAD_LO = 8'h40;
   localparam logic [7:0] OP_LOAD_HI = 8'h48;
   localparam logic [7:0] OP_RD_LO = 8'h20;
   localparam logic [7:0] OP_RD_HI = 8'h28;
   localparam logic [7:0] ERASED = 8'hff;
   localparam int OP_POS = 24;
   localparam int B2_POS = 16;
   localparam int B3_POS = 8;
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] b4;
   } sfp_instr_s;
   typedef enum {SFP_IDLE, SFP_FLASH_BUSY, SFP_EE_BUSY, SFP_ERASE_BUSY} sfp_state_e;
endpackage

/* File: src/sfp_link.sv */
// Link side shifter running on the programmer's serial clock.
`timescale 1ns/1ps
module sfp_link
   import sfp_pkg::*;
(
   input wire logic sck,
   input wire logic reset_pin_n,
   input wire logic mosi,
   output logic miso,
   output logic [31:0] word_r,
   output logic word_tgl_r,
   input wire logic [7:0] rd_byte
);
   logic [4:0] cnt_r;
   logic [31:0] sh_r;
   logic [7:0] tx_r;
   // The clock stops between frames, so reset high clears the counter asynchronously.
   always_ff @(posedge sck or posedge reset_pin_n) begin
      if (reset_pin_n) begin
         cnt_r <= 5'h00;
         sh_r <= 32'h0;
         word_r <= 32'h0;
         word_tgl_r <= 1'b0;
      end else begin
         sh_r <= {sh_r[30:0], mosi}; // RULE3 RULE27
         cnt_r <= cnt_r + 5'h01;
         if (cnt_r == 5'h1f) begin
            word_r <= {sh_r[30:0], mosi};
            word_tgl_r <= ~word_tgl_r;
         end
      end
   end
   // Byte two is echoed as byte three shifts in; byte four carries read data.
   always_ff @(negedge sck or posedge reset_pin_n) begin
      if (reset_pin_n) begin
         tx_r <= 8'h00;
         miso <= 1'b0;
      end else if (cnt_r == 5'h10) begin
         miso <= sh_r[7]; // RULE8 RULE4
         tx_r <= {sh_r[6:0], 1'b0};
      end else if (cnt_r == 5'h18) begin
         miso <= rd_byte[7]; // RULE17 RULE27
         tx_r <= {rd_byte[6:0], 1'b0};
      end else begin
         miso <= tx_r[7]; // RULE4
         tx_r <= {tx_r[6:0], 1'b0};
      end
   end
endmodule

/* File: src/sfp_top.sv */
// Serial programming engine with flash and EEPROM arrays.
`timescale 1ns/1ps
module sfp_top
   import sfp_pkg::*;
#(
   parameter int FLASH_WORDS = 4096,
   parameter int PAGE_WORDS = 32,
   parameter int EE_BYTES = 512,
   parameter int FLASH_CYC = FLASH_WAIT_CYC,
   parameter int EE_CYC = EEPROM_WAIT_CYC,
   parameter int ERASE_CYC = ERASE_WAIT_CYC
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sck,
   input wire logic reset_pin_n,
   input wire logic mosi,
   output logic miso,
   output logic prog_mode_r,
   output logic busy_r
);
   localparam int PW = $clog2(PAGE_WORDS);
   localparam int FW = $clog2(FLASH_WORDS);
   localparam int EW = $clog2(EE_BYTES);
   initial begin
      if (PAGE_WORDS != 32 || FLASH_WORDS != 4096 || EE_BYTES != 512) begin
         $error("sfp_top: address layout fixed by instruction format");
      end
      if (FLASH_CYC < 1 || EE_CYC < 1 || ERASE_CYC < 1) begin
         $error("sfp_top: wait counts must be positive");
      end
   end
   logic [31:0] word_w;
   logic tgl_w;
   logic [7:0] rd_byte_r;
   sfp_link u_link (
      .sck(sck),
      .reset_pin_n(reset_pin_n),
      .mosi(mosi),
      .miso(miso),
      .word_r(word_w),
      .word_tgl_r(tgl_w),
      .rd_byte(rd_byte_r)
   );
   logic rp_s1_r, rp_s2_r, tg_s1_r, tg_s2_r, tg_s3_r;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rp_s1_r <= 1'b1;
         rp_s2_r <= 1'b1;
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         tg_s3_r <= 1'b0;
      end else begin
         rp_s1_r <= reset_pin_n;
         rp_s2_r <= rp_s1_r;
         tg_s1_r <= tgl_w;
         tg_s2_r <= tg_s1_r;
         tg_s3_r <= tg_s2_r;
      end
   end
   // The word is stable for a whole frame after its toggle, so sampling it late is safe.
   logic word_ev;
   sfp_instr_s ins;
   assign word_ev = tg_s2_r ^ tg_s3_r;
   assign ins = sfp_instr_s'(word_w);
   logic [7:0] flash_mem [FLASH_WORDS*2];
   logic [7:0] ee_mem [EE_BYTES];
   logic [7:0] page_lo [PAGE_WORDS];
   logic [7:0] page_hi [PAGE_WORDS];
   sfp_state_e st_r;
   logic [31:0] wait_r;
   logic [FW-PW-1:0] pg_busy_r;
   logic [EW-1:0] ee_busy_r;
   logic [7:0] ee_data_r;
   logic [FW-1:0] erase_idx_r;
   function automatic logic is_op(input sfp_instr_s i, input logic [7:0] op);
      return i.op == op;
   endfunction
   function automatic logic [FW-1:0] faddr(input sfp_instr_s i);
      return {i.b2[3:0], i.b3};
   endfunction
   function automatic logic [EW-1:0] eaddr(input sfp_instr_s i);
      return {i.b2[0], i.b3};
   endfunction
   always_ff @(posedge core_clk) begin
      if (!rstn || rp_s2_r) begin
         prog_mode_r <= 1'b0; // RULE1 RULE22
      end else if (word_ev && is_op(ins, OP_UNLOCK) && ins.b2 == UNLOCK_KEY) begin
         prog_mode_r <= 1'b1; // RULE2 RULE23
      end
   end
   logic act;
   logic [FW-1:0] pg_addr;
   assign act = word_ev && prog_mode_r && st_r == SFP_IDLE;
   assign pg_addr = faddr(ins);
   always_ff @(posedge core_clk) begin
      if (act && (is_op(ins, OP_LOAD_LO) || is_op(ins, OP_LOAD_HI))) begin
         if (ins.op[3]) begin
            page_hi[ins.b3[PW-1:0]] <= ins.b4; // RULE10
         end else begin
            page_lo[ins.b3[PW-1:0]] <= ins.b4; // RULE10
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         st_r <= SFP_IDLE;
         wait_r <= 32'h0;
         pg_busy_r <= '0;
         ee_busy_r <= '0;
         ee_data_r <= 8'h00;
         erase_idx_r <= '0;
         busy_r <= 1'b0;
      end else begin
         case (st_r)
            SFP_IDLE: begin
               busy_r <= 1'b0;
               if (act && is_op(ins, OP_PG_WRITE)) begin
                  st_r <= SFP_FLASH_BUSY; // RULE11 RULE26
                  pg_busy_r <= pg_addr[FW-1:PW];
                  wait_r <= 32'(FLASH_CYC);
                  busy_r <= 1'b1;
               end else if (act && is_op(ins, OP_EE_WRITE)) begin
                  st_r <= SFP_EE_BUSY; // RULE14 RULE25
                  ee_busy_r <= eaddr(ins);
                  ee_data_r <= ins.b4;
                  wait_r <= 32'(EE_CYC);
                  busy_r <= 1'b1;
               end else if (act && is_op(ins, OP_UNLOCK) && ins.b2[7:5] == ERASE_KEY) begin
                  st_r <= SFP_ERASE_BUSY; // RULE24
                  erase_idx_r <= '0;
                  wait_r <= 32'(ERASE_CYC);
                  busy_r <= 1'b1;
               end
            end
            SFP_FLASH_BUSY, SFP_EE_BUSY: begin
               wait_r <= wait_r - 32'h1;
               if (wait_r <= 32'h1) begin
                  st_r <= SFP_IDLE;
                  busy_r <= 1'b0;
               end
            end
            SFP_ERASE_BUSY: begin
               wait_r <= wait_r - 32'h1;
               if (erase_idx_r != '1) begin
                  erase_idx_r <= erase_idx_r + 1'b1;
               end
               // The state ends only once both the wait and the sweep, tracked by erase index, are done.
               if (wait_r <= 32'h1 && erase_idx_r == '1) begin
                  st_r <= SFP_IDLE;
                  busy_r <= 1'b0;
               end
            end
            default: st_r <= SFP_IDLE;
         endcase
      end
   end
   // Page and EEPROM writes commit at the end of the busy time and erase sweeps during it; reads of the busy page or byte return the erased value.
   logic fl_done, ee_done;
   assign fl_done = st_r == SFP_FLASH_BUSY && wait_r <= 32'h1;
   assign ee_done = st_r == SFP_EE_BUSY && wait_r <= 32'h1;
   always_ff @(posedge core_clk) begin
      if (st_r == SFP_ERASE_BUSY) begin
         flash_mem[{erase_idx_r, 1'b0}] <= ERASED; // RULE16
         flash_mem[{erase_idx_r, 1'b1}] <= ERASED; // RULE16
         if (erase_idx_r < FW'(EE_BYTES)) begin
            ee_mem[erase_idx_r[EW-1:0]] <= ERASED; // RULE16
         end
      end else if (fl_done) begin
         for (int k = 0; k < PAGE_WORDS; k++) begin
            flash_mem[{pg_busy_r, PW'(k), 1'b0}] <= page_lo[k]; // RULE11
            flash_mem[{pg_busy_r, PW'(k), 1'b1}] <= page_hi[k]; // RULE11
         end
      end else if (ee_done) begin
         ee_mem[ee_busy_r] <= ee_data_r; // RULE14
      end
   end
   // Read data is prepared after the whole frame; the link launches it at byte four of the next frame.
   logic [31:0] part_w;
   logic [FW-1:0] pa;
   logic [EW-1:0] ea;
   assign part_w = word_w;
   assign pa = {part_w[B2_POS+3:B2_POS], part_w[B3_POS+7:B3_POS]};
   assign ea = {part_w[B2_POS], part_w[B3_POS+7:B3_POS]};
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rd_byte_r <= 8'h00;
      end else if (word_ev && prog_mode_r) begin
         if (is_op(ins, OP_RD_LO) || is_op(ins, OP_RD_HI)) begin
            if (st_r == SFP_FLASH_BUSY && pa[FW-1:PW] == pg_busy_r) begin
               rd_byte_r <= ERASED; // RULE18
            end else begin
               rd_byte_r <= flash_mem[{pa, ins.op[3]}]; // RULE17
            end
         end else if (is_op(ins, OP_EE_READ)) begin
            if (st_r == SFP_EE_BUSY && ea == ee_busy_r) begin
               rd_byte_r <= ERASED; // RULE20
            end else begin
               rd_byte_r <= ee_mem[ea]; // RULE17
            end
         end
      end
   end
endmodule

/* File: bench/sfp_properties.sv */
// Checker on the pins of the programming engine.
`timescale 1ns/1ps
module sfp_properties
   import sfp_pkg::*;
#(
   parameter int FLASH_CYC = FLASH_WAIT_CYC,
   parameter int ERASE_CYC = ERASE_WAIT_CYC
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sck,
   input wire logic reset_pin_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic prog_mode_r,
   input wire logic busy_r
);
   int busy_cnt_r;
   always_ff @(posedge core_clk) begin
      if (!rstn || !busy_r) begin
         busy_cnt_r <= 0;
      end else begin
         busy_cnt_r <= busy_cnt_r + 1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_pin_release;
      $rose(reset_pin_n) ##1 reset_pin_n [*2];
   endsequence
   sequence s_busy_done;
      busy_r ##1 !busy_r;
   endsequence
   a_pin_release_drop: assert property (s_pin_release |=> !prog_mode_r)
      else $error("mode kept after pin release");
   a_unlock_pin_low: assert property ($rose(prog_mode_r) |-> !reset_pin_n && sck)
      else $error("mode rose outside frame end");
   a_busy_after_unlock: assert property ($rose(busy_r) |-> $past(prog_mode_r))
      else $error("write started while locked");
   a_busy_frame_end: assert property ($rose(busy_r) |-> sck && !reset_pin_n)
      else $error("write started outside frame end");
   a_miso_on_fall: assert property (disable iff (!rstn || reset_pin_n)
      $changed(miso) |-> $fell(sck))
      else $error("output moved off falling clock");
   a_busy_min_len: assert property (s_busy_done |-> busy_cnt_r >= FLASH_CYC - 1)
      else $error("write ended too early");
   a_busy_max_len: assert property (busy_r |-> busy_cnt_r <= ERASE_CYC + 1)
      else $error("write runs too long");
   a_busy_holds: assert property ($rose(busy_r) |=> busy_r [*8])
      else $error("busy glitched");
endmodule
bind sfp_top sfp_properties #(.FLASH_CYC(FLASH_CYC), .ERASE_CYC(ERASE_CYC)) u_props (
   .core_clk(core_clk), .rstn(rstn), .sck(sck), .reset_pin_n(reset_pin_n), .mosi(mosi),
   .miso(miso), .prog_mode_r(prog_mode_r), .busy_r(busy_r));

/* File: bench/sfp_prog_model.sv */
// Behavioural programmer that drives the serial programming pins.
`timescale 1ns/1ps
module sfp_prog_model (
   output logic sck,
   output logic mosi,
   output logic reset_pin_n,
   input wire logic miso
);
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      reset_pin_n = 1'b0;
   end
   // The settle wait is scaled down so the run stays short.
   task automatic pin(input logic v);
      reset_pin_n = v;
      #2000;
   endtask
   // Phases of 80 ns keep ten core cycles; the frame lasts a whole number of core cycles.
   task automatic xfer(input logic [31:0] w, output logic [31:0] r);
      #3;
      for (int i = 31; i >= 0; i--) begin
         mosi = w[i];
         #80 sck = 1'b1;
         r[i] = miso;
         #80 sck = 1'b0;
      end
      mosi = ~mosi;
      #5;
   endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the serial programming engine.
`timescale 1ns/1ps
module testbench
   import sfp_pkg::*;
;
   logic core_clk;
   logic rstn;
   logic sck;
   logic mosi;
   logic reset_pin_n;
   logic miso;
   logic prog_mode_r;
   logic busy_r;
   logic [31:0] r;
   logic [7:0] d;
   int err_count;
   int tests_run;
   sfp_top #(.FLASH_CYC(4000), .EE_CYC(4000), .ERASE_CYC(5000)) i_dut (.core_clk(core_clk),
      .rstn(rstn), .sck(sck), .reset_pin_n(reset_pin_n), .mosi(mosi), .miso(miso),
      .prog_mode_r(prog_mode_r), .busy_r(busy_r));
   sfp_prog_model i_prog (.sck(sck), .mosi(mosi), .reset_pin_n(reset_pin_n), .miso(miso));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Read data comes one frame late, so each read is sent twice.
   task automatic rd(input logic [23:0] a, output logic [7:0] v);
      i_prog.xfer({a, 8'h00}, r);
      i_prog.xfer({a, 8'h00}, r);
      v = r[7:0];
   endtask
   task automatic wait_idle();
      chk({7'h0, busy_r}, 8'h01);
      for (int n = 0; n < 6000 && busy_r !== 1'b0; n++) begin
         @(posedge core_clk);
      end
      chk({7'h0, busy_r}, 8'h00);
   endtask
   task automatic t_locked();
      i_prog.xfer({OP_EE_WRITE, 24'h0005a5}, r);
      repeat (8) @(posedge core_clk);
      chk({6'h0, prog_mode_r, busy_r}, 8'h00);
      $display("locked done");
   endtask
   task automatic t_unlock();
      i_prog.xfer({OP_UNLOCK, UNLOCK_KEY, 16'h0000}, r);
      chk(r[15:8], 8'h53);
      chk({7'h0, prog_mode_r}, 8'h01);
      i_prog.xfer({OP_UNLOCK, 8'h9f, 16'h0000}, r);
      wait_idle();
      rd({OP_RD_HI, 16'h0fff}, d);
      chk(d, ERASED);
      rd({OP_EE_READ, 16'h01ff}, d);
      chk(d, ERASED);
      $display("unlock done");
   endtask
   task automatic t_eeprom();
      i_prog.xfer({OP_EE_WRITE, 24'h01235a}, r);
      rd({OP_EE_READ, 16'h0123}, d);
      chk(d, ERASED);
      wait_idle();
      rd({OP_EE_READ, 16'h0123}, d);
      chk(d, 8'h5a);
      i_prog.xfer({OP_EE_WRITE, 24'h0123a5}, r);
      wait_idle();
      rd({OP_EE_READ, 16'h0123}, d);
      chk(d, 8'ha5);
      $display("eeprom done");
   endtask
   task automatic t_flash();
      i_prog.xfer({OP_LOAD_LO, 24'h000311}, r);
      i_prog.xfer({OP_LOAD_HI, 24'h000322}, r);
      i_prog.xfer({OP_PG_WRITE, 24'h002000}, r);
      rd({OP_RD_HI, 16'h0023}, d);
      chk(d, ERASED);
      wait_idle();
      rd({OP_RD_LO, 16'h0023}, d);
      chk(d, 8'h11);
      rd({OP_RD_HI, 16'h0023}, d);
      chk(d, 8'h22);
      i_prog.pin(1'b1);
      chk({7'h0, prog_mode_r}, 8'h00);
      $display("flash done");
   endtask
   initial begin
      err_count = 0;
      tests_run = 0;
      rstn <= 1'b0;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      // The link logic only clears while the pin is high, so pulse it before the first frame.
      i_prog.pin(1'b1);
      i_prog.pin(1'b0);
      t_locked();
      t_unlock();
      t_eeprom();
      t_flash();
      tally_and_finish();
   end
   // About twenty-four frames and four long waits need well under this span.
   initial begin
      #700000;
      err_count++;
      tally_and_finish();
   end
endmodule
